// >>> core/sdf_regs.svh
// Constants of the sinc3 decimation filter: widths, ratio limits and full-scale codes.
// Assumes inclusion by bare name from the filter's design files.
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH

`define SDF_ACC_W        37
`define SDF_WORD_W       16
`define SDF_RATIO_W      16
`define SDF_RATIO_MIN    16'h0020
`define SDF_RATIO_MAX    16'h1000
`define SDF_RATIO_RESET  16'h0100
`define SDF_FULL_SCALE17 17'h1_0000
`define SDF_FULL_SCALE16 16'h8000
`define SDF_SAT_WORD     16'hFFFF
`define SDF_FIFO_DEPTH   4
`define SDF_SYNC_STAGES  2

`endif

// >>> core/sdf_pkg.sv
// Types shared by the sinc3 decimation filter files.
// Assumes the constants header is on the include path.
`include "sdf_regs.svh"

package sdf_pkg;
   typedef logic [`SDF_ACC_W-1:0]   sdf_acc_t;
   typedef logic [`SDF_WORD_W-1:0]  sdf_word_t;
   typedef logic [`SDF_RATIO_W-1:0] sdf_ratio_t;
endpackage

// >>> core/sdf_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module sdf_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("sdf_fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } sdf_fifo_s;

   sdf_fifo_s st_q;
   sdf_fifo_s st_d;
   logic      push;
   logic      pop;

   assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_q.cnt != '0);
   assign out_data  = st_q.mem[st_q.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wr] = in_data;
         st_d.wr           = st_q.wr + 1'b1;
      end
      if (pop)
         st_d.rd = st_q.rd + 1'b1;
      if (push && !pop)
         st_d.cnt = st_q.cnt + 1'b1;
      else if (pop && !push)
         st_d.cnt = st_q.cnt - 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         st_q <= '0;
      else if (clk_en)
         st_q <= st_d;
   end
endmodule

`default_nettype wire

// >>> core/sdf_sinc3.sv
// Sinc3 decimation filter for a single-bit sigma-delta bitstream.
// Assumes the modulator drives its bit clock and data; the host reads words on clk.
`timescale 1ns/10ps
`default_nettype none
`include "sdf_regs.svh"

// Operation
// - Reconstruct the bitstream with a third-order sinc filter that also decimates.
// - Response equals the normalised moving-sum kernel raised to the third power.
// - One output word per ratio modulator clock cycles.
// - Datapath width sized for the largest ratio: three times log2 of it, plus one.
// - Deliver a 16-bit result from the top bits of the comb output.
// - Half-power cutoff sits at 0.262 times the word rate.
// - At 10 MHz, ratios 32 to 512 give the tabled word rates and widths.
// - Sample the modulator data bit on the falling modulator clock edge.
// - Accept a 16-bit power-of-two decimation ratio from 32 up to 4096; other values run as 256.
// - Map a low bit to zero, optionally minus one, and a high bit to one.
// - Three cascaded 37-bit accumulators add the previous stage every bit.
// - Accumulators update on the falling edge and clear on reset.
// - Present a registered 16-bit word and a word-valid output.
// - Three comb differentiators run once per word, not at bit rate.
// - Counter wraps at ratio minus one; the word toggle flips at half, the combs run at end.
// - Select output bits by ratio; full-scale field saturates to all ones.
// - Word-valid stays high until the host takes the word and is low after reset.
module sdf_sinc3
   import sdf_pkg::*;
#(
   parameter int  ACC_W      = `SDF_ACC_W,
   parameter int  FIFO_DEPTH = `SDF_FIFO_DEPTH,
   parameter bit  TWOS_COMP  = 1'b0
) (
   // System clock domain
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // Modulator link
   input  wire logic       filter_clock_in,
   input  wire logic       bitstream_in,
   // Configuration
   input  wire sdf_ratio_t dec_ratio,
   // Filtered word output
   output sdf_word_t       word_out,
   output logic            word_valid,
   input  wire logic       word_ready,
   output logic            word_overrun
);

   initial begin
      if (ACC_W != `SDF_ACC_W)
         $error("sdf_sinc3 datapath must be 37 bits for ratios up to 4096");
      if (FIFO_DEPTH < 2)
         $error("sdf_sinc3 needs a FIFO depth of at least 2");
   end

   // ---------------------------------------------------------------
   // Decimation helpers
   // ---------------------------------------------------------------
   // Returns log2 of a supported ratio, or zero when the ratio is not supported.
   function automatic logic [3:0] ratio_log2(input sdf_ratio_t r);
      logic [3:0] l;
      l = 4'h0;
      for (int i = 5; i <= 12; i++) begin
         if (r == sdf_ratio_t'(1 << i))
            l = 4'(i);
      end
      return l;
   endfunction

   // Picks 16 bits out of the comb result and saturates at full scale.
   function automatic sdf_word_t pick_word(input sdf_acc_t c, input logic [3:0] l);
      logic [16:0] fld;
      sdf_word_t   w;
      fld = 17'h0_0000;
      w   = 16'h0000;
      if (l == 4'h5) begin
         w = (c[15:0] == `SDF_FULL_SCALE16) ? `SDF_SAT_WORD : {c[14:0], 1'b0};
      end else begin
         fld = 17'(c >> (3*l - 16));
         w   = (fld == `SDF_FULL_SCALE17) ? `SDF_SAT_WORD : fld[15:0];
      end
      return w;
   endfunction

   // ---------------------------------------------------------------
   // Link domain: integrators, counter and combs on the falling edge
   // ---------------------------------------------------------------
   typedef struct packed {
      sdf_acc_t   integrator_stage_one;
      sdf_acc_t   integ2;
      sdf_acc_t   integ3;
      sdf_ratio_t word_count;
      sdf_acc_t   integ3_dly;
      sdf_acc_t   comb1;
      sdf_acc_t   comb2;
      sdf_acc_t   comb_stage_three;
      sdf_acc_t   comb1_dly;
      sdf_acc_t   comb2_dly;
      sdf_word_t  word;
      logic       word_tgl;
   } sdf_link_s;

   sdf_link_s  lk_q;
   sdf_link_s  lk_d;
   sdf_acc_t   bit_to_word_input;
   sdf_ratio_t ratio_sync;
   logic [3:0] ratio_l2;
   logic [2:0] rst_link_q;
   logic       link_rst;

   // Ratio is quasi-static; it is held in the link domain through two stages.
   sdf_ratio_t ratio_s1_q;
   sdf_ratio_t ratio_s2_q;

   always_ff @(negedge filter_clock_in) begin
      ratio_s1_q <= dec_ratio;
      ratio_s2_q <= ratio_s1_q;
      rst_link_q <= {rst_link_q[1:0], reset_n};
   end

   assign link_rst   = !rst_link_q[2];
   assign ratio_sync = (ratio_log2(ratio_s2_q) != 4'h0) ? ratio_s2_q : `SDF_RATIO_RESET;
   assign ratio_l2   = ratio_log2(ratio_sync);

   always_comb begin
      // A low bit maps to zero, or to minus one when two's complement is chosen.
      if (bitstream_in)
         bit_to_word_input = sdf_acc_t'(1);
      else
         bit_to_word_input = TWOS_COMP ? '1 : '0;
   end

   always_comb begin
      lk_d = lk_q;
      lk_d.integrator_stage_one = lk_q.integrator_stage_one + bit_to_word_input;
      lk_d.integ2               = lk_q.integ2 + lk_q.integrator_stage_one;
      lk_d.integ3               = lk_q.integ3 + lk_q.integ2;
      if (lk_q.word_count == ratio_sync - 16'h0001)
         lk_d.word_count = 16'h0000;
      else
         lk_d.word_count = lk_q.word_count + 16'h0001;
      // The comb runs once per word, where the strobe would fall.
      if (lk_q.word_count == ratio_sync - 16'h0001) begin
         lk_d.comb1            = lk_q.integ3 - lk_q.integ3_dly;
         lk_d.comb2            = lk_q.comb1 - lk_q.comb1_dly;
         lk_d.comb_stage_three = lk_q.comb2 - lk_q.comb2_dly;
         lk_d.integ3_dly       = lk_q.integ3;
         lk_d.comb1_dly        = lk_q.comb1;
         lk_d.comb2_dly        = lk_q.comb2;
         lk_d.word             = pick_word(lk_q.comb_stage_three, ratio_l2);
      end
      // The word is handed over at the mid-point count, half a word after it settled.
      if (lk_q.word_count == (ratio_sync >> 1) - 16'h0001)
         lk_d.word_tgl = !lk_q.word_tgl;
   end

   // Data is taken on the falling modulator clock edge.
   always_ff @(negedge filter_clock_in) begin
      if (link_rst)
         lk_q <= '0;
      else
         lk_q <= lk_d;
   end

   // ---------------------------------------------------------------
   // System domain: toggle crossing, FIFO and output register
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] tgl_sync;
      sdf_word_t  word_out;
      logic       word_valid;
      logic       word_overrun;
   } sdf_sys_s;

   sdf_sys_s  sy_q;
   sdf_sys_s  sy_d;
   logic      new_word;
   logic      f_in_ready;
   logic      f_out_valid;
   logic      f_pop;
   sdf_word_t f_out_data;

   // The word is stable for half a word period around the toggle, so it is read directly.
   assign new_word = sy_q.tgl_sync[2] ^ sy_q.tgl_sync[1];
   assign f_pop    = f_out_valid && (!sy_q.word_valid || word_ready);

   sdf_fifo #(
      .WIDTH (`SDF_WORD_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .in_valid  (new_word),
      .in_ready  (f_in_ready),
      .in_data   (lk_q.word),
      .out_valid (f_out_valid),
      .out_ready (f_pop),
      .out_data  (f_out_data)
   );

   always_comb begin
      sy_d          = sy_q;
      sy_d.tgl_sync = {sy_q.tgl_sync[1:0], lk_q.word_tgl};
      if (f_pop) begin
         sy_d.word_out   = f_out_data;
         sy_d.word_valid = 1'b1;
      end else if (word_ready) begin
         sy_d.word_valid = 1'b0;
      end
      sy_d.word_overrun = new_word && !f_in_ready;
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         sy_q <= '0;
      else if (clk_en)
         sy_q <= sy_d;
   end

   assign word_out     = sy_q.word_out;
   assign word_valid   = sy_q.word_valid;
   assign word_overrun = sy_q.word_overrun;
endmodule

`default_nettype wire

// >>> bench/sdf_sinc3_assertions.sv
// Checker for the host-side outputs of the sinc3 filter.
// Assumes it is bound to sdf_sinc3 and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module sdf_sinc3_chk
   import sdf_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   // System domain
   input wire logic      clk,
   input wire logic      reset_n,
   input wire logic      clk_en,
   // Word output
   input wire sdf_word_t word_out,
   input wire logic      word_valid,
   input wire logic      word_ready,
   input wire logic      word_overrun
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // Output rules
   // ----------------------------------------------------------------
   a_start_valid_low: assert property ($rose(reset_n) |-> !word_valid [*8])
      else $error("valid too soon after reset");
   a_start_word_zero: assert property ($rose(reset_n) |-> word_out == 16'h0000)
      else $error("word not cleared by reset");
   a_start_no_ovr: assert property ($rose(reset_n) |-> !word_overrun)
      else $error("overrun during reset");
   a_word_stands: assert property (word_valid && !(word_ready && clk_en) |=> word_valid && $stable(word_out))
      else $error("unread word lost");
   a_freeze_holds: assert property (!clk_en |=> $stable(word_out) && $stable(word_valid))
      else $error("output moved while frozen");
   a_load_sets_valid: assert property ($changed(word_out) |-> word_valid)
      else $error("word changed without valid");
   // A frozen clock enable legitimately holds the pulse, so only an enabled edge must clear it.
   a_ovr_one_cycle: assert property (word_overrun && clk_en |=> !word_overrun)
      else $error("overrun longer than one cycle");
   a_ovr_when_full: assert property (word_overrun |-> $past(word_valid) && word_valid)
      else $error("overrun with output free");

   c_accept:   cover property (word_valid && word_ready && clk_en);
   c_overrun:  cover property (word_overrun);
   c_saturate: cover property (word_valid && word_out == 16'hFFFF);
   c_frozen:   cover property (word_valid && !clk_en);
endmodule

bind sdf_sinc3 sdf_sinc3_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_sdf_sinc3_chk (
   .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .word_out(word_out),
   .word_valid(word_valid), .word_ready(word_ready), .word_overrun(word_overrun));

`default_nettype wire

// >>> bench/sdf_mod_model.sv
// Behavioural isolated modulator: free-running bit clock and data bit.
// Assumes the bench selects the data pattern through mode.
`timescale 1ns/10ps
`default_nettype none

module sdf_mod_model (
   // Pattern: 0 all low, 1 all high, 2 alternating
   input wire logic [1:0] mode,
   // Modulator link
   output var logic       mod_clk,
   output var logic       mod_bit
);
   // The bit clock never stops and is offset from the system clock.
   initial begin
      mod_clk = 1'b0;
      mod_bit = 1'b0;
      #37;
      forever #80 mod_clk = ~mod_clk;
   end

   // Data moves after the rising edge so it is settled at the falling edge.
   always @(posedge mod_clk) begin
      mod_bit <= (mode == 2'd2) ? ~mod_bit : mode[0];
   end
endmodule

`default_nettype wire

// >>> bench/sdf_sinc3_test.sv
// Self-checking bench for the sinc3 filter driven by a modulator model.
// Assumes the checker binds itself to the filter.
`timescale 1ns/10ps
`default_nettype none

module sdf_sinc3_test
   import sdf_pkg::*;
();
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        word_ready = 1'b0;
   logic        hold = 1'b0;
   logic [1:0]  mode = 2'd2;
   sdf_ratio_t  dec_ratio = 16'h0100;
   sdf_word_t   word_out;
   logic        word_valid;
   logic        word_overrun;
   wire logic   fclk;
   wire logic   fbit;
   int          miscompares = 0;
   int          checked = 0;
   int          ovr_seen = 0;
   int          seed = 32'h6a55_63cc;
   logic [16:0] expq[$];

   sdf_mod_model u_sdf_mod_model (.mode(mode), .mod_clk(fclk), .mod_bit(fbit));
   sdf_sinc3 #(.FIFO_DEPTH(4)) u_sdf_sinc3 (
      .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .filter_clock_in(fclk), .bitstream_in(fbit),
      .dec_ratio(dec_ratio), .word_out(word_out), .word_valid(word_valid), .word_ready(word_ready),
      .word_overrun(word_overrun));

   initial forever #25 clk = ~clk;

   // ----------------------------------------------------------------
   // Checking and verdict
   // ----------------------------------------------------------------
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Host side: random stalls and freezes, held off while a scenario fills the buffer.
   always @(negedge clk) begin
      clk_en <= !reset_n || (($random(seed) & 7) != 0);
      word_ready <= !hold && (($random(seed) & 1) != 0);
   end

   // Each accepted word is compared with the oldest note; marked notes are settling words.
   always @(posedge clk) begin
      if (reset_n && word_overrun) ovr_seen++;
      if (reset_n && clk_en && word_valid && word_ready && expq.size() > 0) begin
         if (!expq[0][16]) check({1'b0, word_out}, expq[0]);
         void'(expq.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic run(input sdf_ratio_t r, input logic [1:0] m, input sdf_word_t e, input bit ovr);
      int n;
      int k;
      @(negedge clk);
      reset_n <= 1'b0;
      dec_ratio <= r;
      mode <= m;
      hold <= ovr;
      ovr_seen = 0;
      repeat (14) @(negedge clk);
      reset_n <= 1'b1;
      // The first handed word is the reset word and the comb pipeline needs six more to fill.
      for (n = 0; n < 9; n++) expq.push_back(n < 7 ? 17'h1_0000 : {1'b0, e});
      if (ovr) begin
         repeat (r * 26) @(negedge clk);
         check({16'h0000, ovr_seen != 0}, 17'h0_0001);
         hold <= 1'b0;
      end
      for (k = 0; k < 40000 && expq.size() > 0; k++) @(negedge clk);
      if (expq.size() > 0) begin
         miscompares++;
         print_verdict();
      end
   endtask

   initial begin
      for (int i = 5; i <= 10; i++) run(16'h0001 << i, 2'd2, 16'h8000, 1'b0);
      run(16'h0020, 2'd1, 16'hFFFF, 1'b1);
      run(16'h0040, 2'd0, 16'h0000, 1'b0);
      run(16'h0064, 2'd2, 16'h8000, 1'b0);
      print_verdict();
   end
endmodule

`default_nettype wire
